// File: core/dpio_pkg.sv
// Shared constants for the dual parallel port block.
package dpio_pkg;

  // Port and register-select geometry.
  localparam int PORT_W = 8;
  localparam int SEL_W  = 4;

  // Register-select indices.
  localparam logic [3:0] REG_PORT_B_DATA       = 4'h0;
  localparam logic [3:0] REG_PORT_A_DATA       = 4'h1;
  localparam logic [3:0] REG_PORT_B_DIRECTION  = 4'h2;
  localparam logic [3:0] REG_PORT_A_DIRECTION  = 4'h3;
  localparam logic [3:0] REG_PORT_A_DATA_QUIET = 4'hf;

  // Values after reset, and the value of an unmapped read.
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_OUTPUT    = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic       RST_CTL_LEVEL = 1'b0;

  // Latch unit state.
  typedef enum logic [1:0] {
    DPIO_LATCH_OPEN = 2'b01,
    DPIO_LATCH_HELD = 2'b10
  } dpio_latch_type;

endpackage

// File: core/dpio_latch.sv
// Input register of one port: transparent or captured on a control-line edge.
`timescale 1ns/1ns
module dpio_latch #(
  parameter int WIDTH         = dpio_pkg::PORT_W,
  parameter bit CLEAR_ON_READ = 1'b1
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  // Port lines and control line
  input  wire logic [WIDTH-1:0] lines_in,
  input  wire logic             ctl_line_in,
  // Mode
  input  wire logic             latch_en_in,
  input  wire logic             rise_sel_in,
  input  wire logic             read_in,
  // Input register contents
  output logic      [WIDTH-1:0] value_out
);
  import dpio_pkg::*;

  logic                 ctl_prev_ff;
  logic [WIDTH-1:0]     captured_ff;
  dpio_latch_type       state_ff;
  dpio_latch_type       nxt_state;
  logic                 act_edge;

  generate
    if (WIDTH < 1 || WIDTH > PORT_W) begin : g_bad_width
      $error("dpio_latch: WIDTH out of range");
    end
  endgenerate

  // Edge polarity chosen by one bit: low picks falling, high picks rising. [RQ14]
  assign act_edge = rise_sel_in ? (ctl_line_in & ~ctl_prev_ff) : (~ctl_line_in & ctl_prev_ff);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_prev_ff <= RST_CTL_LEVEL;
    end else begin
      ctl_prev_ff <= ctl_line_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      captured_ff <= '0;
    end else if (act_edge) begin
      captured_ff <= lines_in; // [RQ8] [RQ12]
    end
  end

  // An edge in the same cycle as a read wins, so a fresh capture is never lost.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DPIO_LATCH_OPEN: begin
        if (latch_en_in && act_edge) begin
          nxt_state = DPIO_LATCH_HELD; // [RQ8]
        end
      end
      DPIO_LATCH_HELD: begin
        if (!latch_en_in) begin
          nxt_state = DPIO_LATCH_OPEN;
        end else if (act_edge) begin
          nxt_state = DPIO_LATCH_HELD;
        end else if (CLEAR_ON_READ && read_in) begin
          nxt_state = DPIO_LATCH_OPEN; // [RQ9]
        end
      end
      default: begin
        nxt_state = DPIO_LATCH_OPEN;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= DPIO_LATCH_OPEN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Latching off means live levels; held means the captured word. [RQ7] [RQ13]
  assign value_out = (latch_en_in && state_ff == DPIO_LATCH_HELD) ? captured_ff : lines_in;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_capture;
    latch_en_in && act_edge;
  endsequence

  sequence s_quiet_cycle;
    latch_en_in && !act_edge && !read_in;
  endsequence

  a_capture_holds: assert property (
    s_capture ##1 s_quiet_cycle |-> value_out == $past(lines_in)) // [RQ8]
    else $error("Captured word not held after active edge.");

  a_read_releases: assert property (
    (CLEAR_ON_READ && state_ff == DPIO_LATCH_HELD && read_in && !act_edge && latch_en_in)
    |=> value_out == lines_in) // [RQ9]
    else $error("Input register not transparent after read.");

  a_edge_polarity: assert property (
    (latch_en_in && rise_sel_in && $rose(ctl_line_in)) |=> state_ff == DPIO_LATCH_HELD) // [RQ14]
    else $error("Rising edge did not capture with rising edge selected.");

endmodule // dpio_latch

// File: core/dpio_top.sv
// Two 8-bit bidirectional ports behind a 4-bit register-select host bus.
//
// Notes on behaviour
// RQ1: Select decodes sixteen registers; 0,1,2,3 are ports; F aliases port A quietly.
// RQ2: Two independent 8-bit ports, each line direction set by software.
// RQ3: Direction bit 0 makes the line an input, 1 an output.
// RQ4: An output line drives its output register bit level.
// RQ5: Output bits of input lines are stored but reach the pin later.
// RQ6: Reading a port data register returns that port's input register.
// RQ7: Without latching, port A input register follows the live line levels.
// RQ8: With latching, port A holds levels captured at the active A1 edge.
// RQ9: After reading latched port A, it turns transparent until next edge.
// RQ10: Port B output lines read back the stored output register bit.
// RQ11: Port A output lines read back the sensed pin level.
// RQ12: With latching, port B input lines read levels at last B1 edge.
// RQ13: Separate latch-enable bits for each port come from auxiliary control.
// RQ14: A peripheral control bit selects edge: 0 falling, 1 rising.
// RQ15: Reset clears both direction and both output registers.
`timescale 1ns/1ns
module dpio_top #(
  parameter int WIDTH = dpio_pkg::PORT_W
) (
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_b_in,
  // Host register bus
  input  wire logic                    cs_in,
  input  wire logic                    rw_in,
  input  wire logic [dpio_pkg::SEL_W-1:0] reg_sel_in,
  input  wire logic [WIDTH-1:0]        wr_data_in,
  output logic      [WIDTH-1:0]        rd_data_out,
  // Handshake access strobes
  output logic                         port_a_access_out,
  output logic                         port_b_access_out,
  // Mode bits held in control registers outside this block
  input  wire logic                    port_a_latch_en_in,
  input  wire logic                    port_b_latch_en_in,
  input  wire logic                    a1_rise_sel_in,
  input  wire logic                    b1_rise_sel_in,
  // Control lines
  input  wire logic                    control_line_a1_in,
  input  wire logic                    control_line_b1_in,
  // Port A lines
  input  wire logic [WIDTH-1:0]        port_a_lines_in,
  output logic      [WIDTH-1:0]        port_a_lines_out,
  output logic      [WIDTH-1:0]        port_a_lines_oe_out,
  // Port B lines
  input  wire logic [WIDTH-1:0]        port_b_lines_in,
  output logic      [WIDTH-1:0]        port_b_lines_out,
  output logic      [WIDTH-1:0]        port_b_lines_oe_out
);
  import dpio_pkg::*;

  logic [WIDTH-1:0] port_a_output_reg_ff;
  logic [WIDTH-1:0] port_b_output_reg_ff;
  logic [WIDTH-1:0] port_a_direction_ff;
  logic [WIDTH-1:0] port_b_direction_ff;
  logic [WIDTH-1:0] rd_data_ff;
  logic [WIDTH-1:0] nxt_rd_data;
  logic [WIDTH-1:0] port_a_input_reg;
  logic [WIDTH-1:0] port_b_input_reg;
  logic             wr_strobe;
  logic             rd_strobe;
  logic             port_a_read;

  generate
    if (WIDTH != PORT_W) begin : g_bad_width
      $error("dpio_top: only 8-bit ports are supported");
    end
  endgenerate

  // Port A data decodes at two indices; only index 1 carries handshake effects.
  function automatic logic sel_is_port_a(input logic [SEL_W-1:0] sel);
    sel_is_port_a = (sel == REG_PORT_A_DATA) || (sel == REG_PORT_A_DATA_QUIET);
  endfunction

  assign wr_strobe = cs_in && !rw_in;
  assign rd_strobe = cs_in && rw_in;
  assign port_a_read = rd_strobe && sel_is_port_a(reg_sel_in);

  // The quiet alias stays off this strobe so it never disturbs a handshake. [RQ1]
  assign port_a_access_out = cs_in && (reg_sel_in == REG_PORT_A_DATA);
  assign port_b_access_out = cs_in && (reg_sel_in == REG_PORT_B_DATA);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_a_output_reg_ff <= RST_OUTPUT; // [RQ15]
    end else if (wr_strobe && sel_is_port_a(reg_sel_in)) begin
      port_a_output_reg_ff <= wr_data_in; // [RQ1] [RQ5]
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_b_output_reg_ff <= RST_OUTPUT; // [RQ15]
    end else if (wr_strobe && reg_sel_in == REG_PORT_B_DATA) begin
      port_b_output_reg_ff <= wr_data_in; // [RQ5]
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_a_direction_ff <= RST_DIRECTION; // [RQ15]
    end else if (wr_strobe && reg_sel_in == REG_PORT_A_DIRECTION) begin
      port_a_direction_ff <= wr_data_in; // [RQ2]
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_b_direction_ff <= RST_DIRECTION; // [RQ15]
    end else if (wr_strobe && reg_sel_in == REG_PORT_B_DIRECTION) begin
      port_b_direction_ff <= wr_data_in; // [RQ2]
    end
  end

  // The output register always sits on the line; the enable decides whether it drives.
  assign port_a_lines_out    = port_a_output_reg_ff; // [RQ4]
  assign port_b_lines_out    = port_b_output_reg_ff; // [RQ4]
  assign port_a_lines_oe_out = port_a_direction_ff;  // [RQ3]
  assign port_b_lines_oe_out = port_b_direction_ff;  // [RQ3]

  // Port A input register sees all eight pins, outputs included. [RQ11]
  dpio_latch #(
    .WIDTH         (WIDTH),
    .CLEAR_ON_READ (1'b1)
  ) u_latch_a (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .lines_in    (port_a_lines_in),
    .ctl_line_in (control_line_a1_in),
    .latch_en_in (port_a_latch_en_in),
    .rise_sel_in (a1_rise_sel_in),
    .read_in     (port_a_read),
    .value_out   (port_a_input_reg)
  );

  // Port B keeps its capture until the next edge, reads do not release it.
  dpio_latch #(
    .WIDTH         (WIDTH),
    .CLEAR_ON_READ (1'b0)
  ) u_latch_b (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .lines_in    (port_b_lines_in),
    .ctl_line_in (control_line_b1_in),
    .latch_en_in (port_b_latch_en_in),
    .rise_sel_in (b1_rise_sel_in),
    .read_in     (1'b0),
    .value_out   (port_b_input_reg)
  );

  // Read data is registered, so loading on a pin never races the bus.
  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (rd_strobe) begin
      case (reg_sel_in)
        REG_PORT_B_DATA: begin
          // Loaded output pins cannot corrupt what port B reads back. [RQ10] [RQ12]
          nxt_rd_data = (port_b_direction_ff & port_b_output_reg_ff)
                      | (~port_b_direction_ff & port_b_input_reg);
        end
        REG_PORT_A_DATA, REG_PORT_A_DATA_QUIET: begin
          nxt_rd_data = port_a_input_reg; // [RQ6] [RQ7]
        end
        REG_PORT_B_DIRECTION: begin
          nxt_rd_data = port_b_direction_ff;
        end
        REG_PORT_A_DIRECTION: begin
          nxt_rd_data = port_a_direction_ff;
        end
        default: begin
          // Timers, shift, control and flag registers live outside this block.
          nxt_rd_data = UNMAPPED_READ; // [RQ1]
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_ff <= RST_READ_DATA;
    end else begin
      rd_data_ff <= nxt_rd_data; // [RQ6]
    end
  end

  assign rd_data_out = rd_data_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Single-cycle bus steps that the multi-cycle properties are built from.
  sequence s_wr_b_data;
    wr_strobe && reg_sel_in == REG_PORT_B_DATA;
  endsequence

  sequence s_bus_idle;
    !cs_in;
  endsequence

  a_dir_a_write: assert property ((wr_strobe && reg_sel_in == REG_PORT_A_DIRECTION)
    |=> port_a_lines_oe_out == $past(wr_data_in)) // [RQ3]
    else $error("Port A enables do not follow direction write.");

  a_out_quiet_write: assert property ((wr_strobe && reg_sel_in == REG_PORT_A_DATA_QUIET)
    |=> port_a_lines_out == $past(wr_data_in) && !$past(port_a_access_out)) // [RQ1]
    else $error("Quiet alias write misbehaved.");

  a_out_b_kept: assert property (s_wr_b_data ##1 s_bus_idle [*2]
    |-> port_b_lines_out == $past(wr_data_in, 2)) // [RQ5]
    else $error("Port B output register lost its value.");

  a_b_read_outputs: assert property ((rd_strobe && reg_sel_in == REG_PORT_B_DATA)
    |=> (rd_data_out & $past(port_b_direction_ff))
        == ($past(port_b_output_reg_ff) & $past(port_b_direction_ff))) // [RQ10]
    else $error("Port B output bits not read from output register.");

  a_a_read_live: assert property ((rd_strobe && reg_sel_in == REG_PORT_A_DATA
    && !port_a_latch_en_in) |=> rd_data_out == $past(port_a_lines_in)) // [RQ7] [RQ11]
    else $error("Port A read does not show live pins.");

  a_unmapped_zero: assert property ((rd_strobe && reg_sel_in > REG_PORT_A_DIRECTION
    && reg_sel_in != REG_PORT_A_DATA_QUIET) |=> rd_data_out == UNMAPPED_READ) // [RQ1]
    else $error("Unmapped register read not zero.");

  a_reset_inputs: assert property (@(posedge clk_in) disable iff (1'b0)
    !rst_b_in |-> port_a_lines_oe_out == RST_DIRECTION
    && port_b_lines_oe_out == RST_DIRECTION) // [RQ15]
    else $error("Lines not inputs during reset.");

  // Reset is checked apart from the default disable, which would otherwise hide it.
  a_reset_outputs: assert property (@(posedge clk_in) disable iff (1'b0)
    !rst_b_in |-> port_a_lines_out == RST_OUTPUT && port_b_lines_out == RST_OUTPUT
    && rd_data_out == RST_READ_DATA) // [RQ15]
    else $error("Output registers or read data not cleared during reset.");

  a_dir_b_write: assert property ((wr_strobe && reg_sel_in == REG_PORT_B_DIRECTION)
    |=> port_b_lines_oe_out == $past(wr_data_in)) // [RQ3]
    else $error("Port B enables do not follow direction write.");

  a_out_a_write: assert property ((wr_strobe && reg_sel_in == REG_PORT_A_DATA)
    |=> port_a_lines_out == $past(wr_data_in)) // [RQ4]
    else $error("Port A output register does not follow write.");

  a_out_b_write: assert property (s_wr_b_data
    |=> port_b_lines_out == $past(wr_data_in)) // [RQ4]
    else $error("Port B output register does not follow write.");

  a_out_a_kept: assert property (!(wr_strobe && sel_is_port_a(reg_sel_in))
    |=> $stable(port_a_lines_out)) // [RQ5]
    else $error("Port A output register changed without a write.");

  a_out_b_stable: assert property (!(wr_strobe && reg_sel_in == REG_PORT_B_DATA)
    |=> $stable(port_b_lines_out)) // [RQ5]
    else $error("Port B output register changed without a write.");

  a_dir_kept: assert property (!(wr_strobe && (reg_sel_in == REG_PORT_A_DIRECTION
    || reg_sel_in == REG_PORT_B_DIRECTION))
    |=> $stable(port_a_lines_oe_out) && $stable(port_b_lines_oe_out)) // [RQ2]
    else $error("Direction register changed without a write.");

  a_quiet_no_strobe: assert property ((cs_in && reg_sel_in == REG_PORT_A_DATA_QUIET)
    |-> !port_a_access_out && !port_b_access_out) // [RQ1]
    else $error("Quiet alias raised an access strobe.");

  a_access_a_only: assert property ((cs_in && reg_sel_in == REG_PORT_A_DATA)
    |-> port_a_access_out && !port_b_access_out) // [RQ1]
    else $error("Port A access strobe wrong.");

  a_access_b_only: assert property ((cs_in && reg_sel_in == REG_PORT_B_DATA)
    |-> port_b_access_out && !port_a_access_out) // [RQ1]
    else $error("Port B access strobe wrong.");

  a_rd_data_stands: assert property (!rd_strobe
    |=> $stable(rd_data_out)) // [RQ6]
    else $error("Read data changed without a read.");

  a_dir_a_read: assert property ((rd_strobe && reg_sel_in == REG_PORT_A_DIRECTION)
    |=> rd_data_out == $past(port_a_lines_oe_out)) // [RQ2]
    else $error("Port A direction read back wrong.");

  a_dir_b_read: assert property ((rd_strobe && reg_sel_in == REG_PORT_B_DIRECTION)
    |=> rd_data_out == $past(port_b_lines_oe_out)) // [RQ2]
    else $error("Port B direction read back wrong.");

  a_a_read_quiet: assert property ((rd_strobe && reg_sel_in == REG_PORT_A_DATA_QUIET
    && !port_a_latch_en_in) |=> rd_data_out == $past(port_a_lines_in)) // [RQ1] [RQ7]
    else $error("Quiet alias read does not show live pins.");

  a_b_read_inputs: assert property ((rd_strobe && reg_sel_in == REG_PORT_B_DATA
    && !port_b_latch_en_in) |=> (rd_data_out & ~$past(port_b_direction_ff))
        == ($past(port_b_lines_in) & ~$past(port_b_direction_ff))) // [RQ6]
    else $error("Port B input bits not read from the pins.");

  // Writes to indices owned by other blocks must leave every port register alone.
  a_unmapped_no_write: assert property ((wr_strobe && reg_sel_in > REG_PORT_A_DIRECTION
    && reg_sel_in != REG_PORT_A_DATA_QUIET)
    |=> $stable(port_a_lines_out) && $stable(port_b_lines_out)
        && $stable(port_a_lines_oe_out) && $stable(port_b_lines_oe_out)) // [RQ1]
    else $error("Unmapped register write changed a port register.");

endmodule // dpio_top

// File: test/dpio_periph.sv
// Peripheral model that resolves each port pin from the device and the far side.
`timescale 1ns/1ns
module dpio_periph (
  // Device side
  input  wire logic [7:0] lines_out_in,
  input  wire logic [7:0] lines_oe_in,
  // Peripheral side
  input  wire logic [7:0] ext_in,
  input  wire logic [7:0] load_in,
  // Resolved pins
  output logic      [7:0] pins_out
);
  // A heavily loaded output is dragged low, so its sensed level can differ from its register.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (lines_oe_in[i]) begin
        pins_out[i] = lines_out_in[i] & ~load_in[i];
      end else begin
        pins_out[i] = ext_in[i];
      end
    end
  end
endmodule // dpio_periph

// File: test/tb_top.sv
// Self-checking testbench for the dual parallel port block.
`timescale 1ns/1ns
module tb_top;
  import dpio_pkg::*;
  logic       clk_in, rst_b_in, cs, rw, en_a, en_b, rise_a, rise_b, a1, b1, acc_a, acc_b;
  logic [3:0] sel;
  logic [7:0] wd, rd_data, a_pins, a_out, a_oe, a_ext, a_load, b_pins, b_out, b_oe, b_ext;
  logic [7:0] r, x;
  logic [7:0] v [6];
  int         fail_count, samples_checked, cycles;

  dpio_top i_dpio_top (.clk_in(clk_in), .rst_b_in(rst_b_in), .cs_in(cs), .rw_in(rw),
    .reg_sel_in(sel), .wr_data_in(wd), .rd_data_out(rd_data), .port_a_access_out(acc_a),
    .port_b_access_out(acc_b), .port_a_latch_en_in(en_a), .port_b_latch_en_in(en_b),
    .a1_rise_sel_in(rise_a), .b1_rise_sel_in(rise_b), .control_line_a1_in(a1),
    .control_line_b1_in(b1), .port_a_lines_in(a_pins), .port_a_lines_out(a_out),
    .port_a_lines_oe_out(a_oe), .port_b_lines_in(b_pins), .port_b_lines_out(b_out),
    .port_b_lines_oe_out(b_oe));
  dpio_periph i_dpio_periph_a (.lines_out_in(a_out), .lines_oe_in(a_oe), .ext_in(a_ext),
    .load_in(a_load), .pins_out(a_pins));
  dpio_periph i_dpio_periph_b (.lines_out_in(b_out), .lines_oe_in(b_oe), .ext_in(b_ext),
    .load_in(8'h00), .pins_out(b_pins));

  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Level the host should read back from a port that senses its pins.
  function automatic logic [7:0] sensed(input logic [7:0] d, o, l, e);
    return (d & o & ~l) | (~d & e);
  endfunction

  task automatic chk(input string n, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    cs = 1'b1;
    rw = 1'b0;
    sel = s;
    wd = d;
    @(posedge clk_in);
    #1;
    cs = 1'b0;
    // An idle edge keeps a following call from raising cs in the same time step.
    @(posedge clk_in);
    #1;
  endtask

  task automatic rd(input string n, input logic [3:0] s, input logic [7:0] e);
    cs = 1'b1;
    rw = 1'b1;
    sel = s;
    #1;
    chk("access_a", {7'h00, acc_a}, {7'h00, s == REG_PORT_A_DATA});
    chk("access_b", {7'h00, acc_b}, {7'h00, s == REG_PORT_B_DATA});
    @(posedge clk_in);
    #1;
    cs = 1'b0;
    chk(n, rd_data, e);
    @(posedge clk_in);
    #1;
  endtask

  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Ceiling sits well above the few hundred cycles that the sequence needs.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    {rst_b_in, cs, rw, en_a, en_b, rise_a, rise_b, a1, b1} = '0;
    {sel, wd, a_ext, a_load, b_ext} = '0;
    r = 8'h0b;
    repeat (12) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    chk("rst_oe", a_oe | b_oe, RST_DIRECTION);
    chk("rst_out", a_out | b_out, RST_OUTPUT);
    for (int k = 0; k < 16; k++) begin
      for (int j = 0; j < 6; j++) begin
        r = nx(r);
        v[j] = r;
      end
      if (k == 0) v[0] = 8'hff;
      wr(REG_PORT_A_DIRECTION, v[0]);
      wr(k[0] ? REG_PORT_A_DATA_QUIET : REG_PORT_A_DATA, v[1]);
      wr(4'(4 + k % 11), v[5]);
      wr(REG_PORT_B_DIRECTION, v[2]);
      wr(REG_PORT_B_DATA, v[3]);
      a_ext = v[4];
      b_ext = v[5];
      a_load = v[4] ^ v[3];
      chk("a_oe", a_oe, v[0]);
      chk("a_out", a_out, v[1]);
      chk("b_oe", b_oe, v[2]);
      chk("b_out", b_out, v[3]);
      @(posedge clk_in);
      #1;
      rd("b_data", REG_PORT_B_DATA, sensed(v[2], v[3], ~v[2], v[5]) | (v[2] & v[3]));
      rd("a_data", REG_PORT_A_DATA, sensed(v[0], v[1], a_load, v[4]));
      rd("a_quiet", REG_PORT_A_DATA_QUIET, sensed(v[0], v[1], a_load, v[4]));
      rd("b_dir", REG_PORT_B_DIRECTION, v[2]);
      rd("a_dir", REG_PORT_A_DIRECTION, v[0]);
      rd("unmapped", 4'(4 + k % 11), UNMAPPED_READ);
    end
    a_load = 8'h00;
    wr(REG_PORT_A_DIRECTION, 8'h00);
    for (int e = 0; e < 2; e++) begin
      rise_a = e[0];
      en_a = 1'b1;
      a1 = ~e[0];
      repeat (2) @(posedge clk_in);
      #1;
      r = nx(r);
      a_ext = r;
      a1 = e[0];
      @(posedge clk_in);
      #1;
      a_ext = ~r;
      rd("a_held", REG_PORT_A_DATA, r);
      rd("a_open", e ? REG_PORT_A_DATA_QUIET : REG_PORT_A_DATA, ~r);
      a1 = ~e[0];
      @(posedge clk_in);
      #1;
      a_ext = r;
      rd("a_wrong_edge", REG_PORT_A_DATA, r);
    end
    en_a = 1'b0;
    wr(REG_PORT_B_DIRECTION, 8'h00);
    en_b = 1'b1;
    rise_b = 1'b1;
    @(posedge clk_in);
    #1;
    x = nx(r);
    b_ext = x;
    b1 = 1'b1;
    @(posedge clk_in);
    #1;
    b_ext = ~x;
    rd("b_held", REG_PORT_B_DATA, x);
    rd("b_held_again", REG_PORT_B_DATA, x);
    en_b = 1'b0;
    rd("b_live", REG_PORT_B_DATA, ~x);
    wr(REG_PORT_A_DIRECTION, 8'h5a);
    rst_b_in = 1'b0;
    #40;
    chk("rerst_oe", a_oe, RST_DIRECTION);
    rst_b_in = 1'b1;
    conclude();
  end
endmodule // tb_top
